// ==== aibf_pkg.sv ====
package aibf_pkg;

    // ***************************************************************
    // register map and fields
    // ***************************************************************
    localparam logic [7:0] ADDR_BLINK_TIMING  = 8'h12;
    localparam logic [7:0] ADDR_FADE_TIMING   = 8'h13;
    localparam logic [7:0] ADDR_SINK0_CURRENT = 8'h14;
    localparam logic [7:0] ADDR_SINK1_CURRENT = 8'h15;
    localparam logic [7:0] ADDR_SINK2_CURRENT = 8'h16;

    localparam int ON_TIME_LSB   = 6;      // shared_on_time, bits 7:6
    localparam int SINK2_OFF_LSB = 4;      // sink2_off_time, bits 5:4
    localparam int SINK1_OFF_LSB = 2;      // sink1_off_time, bits 3:2
    localparam int SINK0_OFF_LSB = 0;      // sink0_off_time, bits 1:0
    localparam int FADE_OUT_LSB  = 4;      // fade_out_time, bits 7:4
    localparam int FADE_IN_LSB   = 0;      // fade_in_time, bits 3:0
    localparam int CODE_W        = 6;      // current code, bits 5:0

    localparam logic [7:0] BLINK_TIMING_RST = 8'h00;
    localparam logic [7:0] FADE_TIMING_RST  = 8'h00;
    localparam logic [5:0] SINK_CODE_RST    = 6'h00;

    // ***************************************************************
    // timing: every documented time is a multiple of 0.1 s; the 0.1 s
    // unit is split into 64 base ticks so a fade can take 64 steps
    // ***************************************************************
    localparam int CLK_KHZ         = 50_000;
    localparam int UNIT_MS         = 100;
    localparam int STEPS_PER_UNIT  = 64;
    localparam int BASE_TICK_CYCLES = (UNIT_MS * CLK_KHZ) / STEPS_PER_UNIT;
    localparam logic [6:0] FADE_FULL = 7'h40;   // fade progress at full code

    // off code that disables a sink's blink timer
    localparam logic [1:0] OFF_TIMER_DISABLED = 2'h0;
    localparam logic [3:0] FADE_DISABLED      = 4'h0;

    // on time and off time in 0.1 s units, indexed by field code
    localparam logic [3:0] ON_TENTHS [4]  = '{4'h2, 4'h6, 4'h8, 4'hc};
    localparam logic [3:0] OFF_TENTHS [4] = '{4'h0, 4'h6, 4'h8, 4'hc};

    typedef enum logic [2:0] {
        SINK_OFF, SINK_FADE_IN, SINK_ON, SINK_FADE_OUT, SINK_DARK
    } aibf_sink_state_type;

endpackage : aibf_pkg

// ==== aibf_sink.sv ====
`timescale 1ns/1ps

// ***************************************************************
// one auxiliary sink: enable, blink and fade engine
// ***************************************************************
module aibf_sink
    import aibf_pkg::*;
(
    input  wire logic              mclk,        // 50 MHz clock
    input  wire logic              reset_n,     // synchronous reset
    input  wire logic              ce,          // clock enable
    input  wire logic              tick,        // base tick pulse
    input  wire logic              enable,      // sink enable bit
    input  wire logic              law,         // 0 linear, 1 square
    input  wire logic              off_disable, // blink timer off
    input  wire logic [3:0]        on_tenths,   // shared on time
    input  wire logic [3:0]        off_tenths,  // own off time
    input  wire logic [5:0]        fi_tenths,   // fade-in, 0 = none
    input  wire logic [5:0]        fo_tenths,   // fade-out, 0 = none
    input  wire logic [CODE_W-1:0] code,        // programmed current code
    output logic [CODE_W-1:0]      level,       // code driven to the sink
    output logic                   lit          // sink conducting
);

    aibf_sink_state_type state, next_state;
    logic [9:0]  cnt, next_cnt;
    logic [6:0]  prog, next_prog;
    logic [12:0] lin_prod;
    logic [19:0] sq_prod;
    logic [CODE_W-1:0] next_level;
    logic [9:0]  on_last, off_last;
    logic [5:0]  fi_last, fo_last;

    // timer end values; each fade step spans one base tick per 0.1 s of fade time
    assign on_last  = {on_tenths, 6'h00} - 10'h001;
    assign off_last = {off_tenths, 6'h00} - 10'h001;
    assign fi_last  = fi_tenths - 6'h01;
    assign fo_last  = fo_tenths - 6'h01;

    // current follows progress along a linear or square law
    assign lin_prod = code * prog;
    assign sq_prod  = lin_prod * prog;

    // next state; a fade that is not enabled is skipped entirely
    always_comb begin
        next_state = state;
        next_cnt   = cnt;
        next_prog  = prog;
        unique case (state)
            SINK_OFF: begin
                next_cnt = 10'h000;
                if (enable) begin
                    next_state = (fi_tenths != 6'h00) ? SINK_FADE_IN : SINK_ON;
                    next_prog  = (fi_tenths != 6'h00) ? 7'h00 : FADE_FULL;
                end
            end
            SINK_FADE_IN: begin
                if (!enable) begin
                    next_state = (fo_tenths != 6'h00) ? SINK_FADE_OUT : SINK_OFF;
                    next_cnt   = 10'h000;
                end else if (tick) begin
                    next_cnt = cnt + 10'h001;
                    if (cnt[5:0] == fi_last) begin
                        next_cnt  = 10'h000;
                        next_prog = prog + 7'h01;
                        if (prog == FADE_FULL - 7'h01)
                            next_state = SINK_ON;
                    end
                end
            end
            SINK_ON: begin
                next_prog = FADE_FULL;
                if (!enable) begin
                    next_state = (fo_tenths != 6'h00) ? SINK_FADE_OUT : SINK_OFF;
                    next_cnt   = 10'h000;
                end else if (off_disable) begin
                    next_cnt = 10'h000;                        // steady on
                end else if (tick) begin
                    next_cnt = cnt + 10'h001;
                    if (cnt >= on_last) begin
                        next_cnt   = 10'h000;
                        next_state = (fo_tenths != 6'h00) ? SINK_FADE_OUT : SINK_DARK;
                    end
                end
            end
            SINK_FADE_OUT: begin
                if (enable && prog == FADE_FULL && off_disable) begin
                    next_state = SINK_ON;                      // timer cleared mid-cycle
                end else if (tick) begin
                    next_cnt = cnt + 10'h001;
                    if (cnt[5:0] == fo_last) begin
                        next_cnt  = 10'h000;
                        next_prog = prog - 7'h01;
                        if (prog == 7'h01)
                            next_state = enable ? SINK_DARK : SINK_OFF;
                    end
                end
            end
            SINK_DARK: begin
                next_prog = 7'h00;
                if (!enable) begin
                    next_state = SINK_OFF;
                end else if (off_disable) begin
                    next_state = SINK_OFF;                     // relights as steady on
                end else if (tick) begin
                    next_cnt = cnt + 10'h001;
                    if (cnt >= off_last) begin
                        next_cnt   = 10'h000;
                        next_state = SINK_OFF;
                    end
                end
            end
        endcase
    end

    // level seen by the sink; off and dark force zero
    always_comb begin
        if (state == SINK_OFF || state == SINK_DARK)
            next_level = '0;
        else if (state == SINK_ON)
            next_level = code;
        else if (law)
            next_level = sq_prod[17:12];
        else
            next_level = lin_prod[11:6];
    end

    // state registers, frozen while ce is low
    always_ff @(posedge mclk) begin
        if (!reset_n) begin
            state <= SINK_OFF;
            cnt   <= 10'h000;
            prog  <= 7'h00;
            level <= '0;
            lit   <= 1'b0;
        end else if (ce) begin
            state <= next_state;
            cnt   <= next_cnt;
            prog  <= next_prog;
            level <= next_level;
            lit   <= (next_level != '0);
        end
    end

endmodule : aibf_sink

// ==== aibf_ctrl.sv ====
`timescale 1ns/1ps

// ***************************************************************
// auxiliary indicator blink and fade control
// ***************************************************************
// Summary of operation
// - one shared on-time for all three sinks
// - on-time codes: 0.2, 0.6, 0.8, 1.2 s
// - per-sink off-time; 00 disables, else 0.6/0.8/1.2
// - disabled off-timer keeps enabled sink steadily lit
// - fade-out: 0 off, 0.3 s steps, then 0.5
// - fade-in uses the same duration table
// - six-bit current code per sink, bits 7:6 unused
// - sinks one and two use their own codes
// - each sink follows its own enable bit
// - fade law: 0 linear, 1 square
module aibf_ctrl
    import aibf_pkg::*;
#(
    parameter int BASE_TICK = BASE_TICK_CYCLES  // cycles per base tick
)
(
    input  wire logic              mclk,         // 50 MHz clock
    input  wire logic              reset_n,      // synchronous reset, active low
    input  wire logic              ce,           // clock enable
    input  wire logic [7:0]        reg_addr,     // register address from serial port
    input  wire logic [7:0]        reg_wdata,    // write byte
    input  wire logic              reg_we,       // write strobe
    input  wire logic              reg_re,       // read strobe
    output logic [7:0]             reg_rdata,    // read byte, registered
    input  wire logic [2:0]        sink_enable,  // per-sink enable bits
    input  wire logic              fade_law_select, // 0 linear, 1 square
    output logic [CODE_W-1:0]      sink0_level,  // code driven to sink 0
    output logic [CODE_W-1:0]      sink1_level,  // code driven to sink 1
    output logic [CODE_W-1:0]      sink2_level,  // code driven to sink 2
    output logic [2:0]             sink_lit      // per-sink conducting
);

    // ***************************************************************
    // registers
    // ***************************************************************
    logic [7:0]        aux_blink_timing;
    logic [7:0]        aux_fade_timing;
    logic [CODE_W-1:0] sink0_current_code;
    logic [CODE_W-1:0] sink1_current_code;
    logic [CODE_W-1:0] sink2_current_code;
    logic [7:0]        next_rdata;

    wire sel_blink = (reg_addr == ADDR_BLINK_TIMING);
    wire sel_fade  = (reg_addr == ADDR_FADE_TIMING);
    wire sel_cur0  = (reg_addr == ADDR_SINK0_CURRENT);
    wire sel_cur1  = (reg_addr == ADDR_SINK1_CURRENT);
    wire sel_cur2  = (reg_addr == ADDR_SINK2_CURRENT);

    // write side; the current registers keep only bits 5:0
    always_ff @(posedge mclk) begin
        if (!reset_n) begin
            aux_blink_timing   <= BLINK_TIMING_RST;
            aux_fade_timing    <= FADE_TIMING_RST;
            sink0_current_code <= SINK_CODE_RST;
            sink1_current_code <= SINK_CODE_RST;
            sink2_current_code <= SINK_CODE_RST;
        end else if (ce && reg_we) begin
            if (sel_blink) aux_blink_timing   <= reg_wdata;
            if (sel_fade)  aux_fade_timing    <= reg_wdata;
            if (sel_cur0)  sink0_current_code <= reg_wdata[CODE_W-1:0];
            if (sel_cur1)  sink1_current_code <= reg_wdata[CODE_W-1:0];
            if (sel_cur2)  sink2_current_code <= reg_wdata[CODE_W-1:0];
        end
    end

    // read mux; unmapped addresses and unused bits read zero
    assign next_rdata = sel_blink ? aux_blink_timing :
                        sel_fade  ? aux_fade_timing :
                        sel_cur0  ? {2'h0, sink0_current_code} :
                        sel_cur1  ? {2'h0, sink1_current_code} :
                        sel_cur2  ? {2'h0, sink2_current_code} : 8'h00;

    // read data held until the next read strobe
    always_ff @(posedge mclk) begin
        if (!reset_n)
            reg_rdata <= 8'h00;
        else if (ce && reg_re)
            reg_rdata <= next_rdata;
    end

    // ***************************************************************
    // field decode
    // ***************************************************************
    // fade duration in 0.1 s units: 0.3 s steps to 3.0 s, then 0.5 s steps
    function automatic logic [5:0] fade_tenths(input logic [3:0] f);
        logic [5:0] t;
        t = 6'h00;
        if (f <= 4'ha)
            t = 6'({f, 1'b0} + {2'h0, f});
        else
            t = 6'(6'd35 + 6'(5 * (f - 4'hb)));
        return t;
    endfunction : fade_tenths

    wire [1:0] shared_on_time = aux_blink_timing[ON_TIME_LSB +: 2];
    wire [1:0] sink2_off_time = aux_blink_timing[SINK2_OFF_LSB +: 2];
    wire [1:0] sink1_off_time = aux_blink_timing[SINK1_OFF_LSB +: 2];
    wire [1:0] sink0_off_time = aux_blink_timing[SINK0_OFF_LSB +: 2];
    wire [3:0] fade_out_time  = aux_fade_timing[FADE_OUT_LSB +: 4];
    wire [3:0] fade_in_time   = aux_fade_timing[FADE_IN_LSB +: 4];

    wire [3:0] on_tenths = ON_TENTHS[shared_on_time];
    wire [5:0] fi_tenths = (fade_in_time == FADE_DISABLED) ? 6'h00 :
                           fade_tenths(fade_in_time);
    wire [5:0] fo_tenths = (fade_out_time == FADE_DISABLED) ? 6'h00 :
                           fade_tenths(fade_out_time);

    wire [1:0] off_code [3];
    assign off_code[0] = sink0_off_time;
    assign off_code[1] = sink1_off_time;
    assign off_code[2] = sink2_off_time;

    wire [CODE_W-1:0] code_sel [3];
    assign code_sel[0] = sink0_current_code;
    assign code_sel[1] = sink1_current_code;
    assign code_sel[2] = sink2_current_code;

    // ***************************************************************
    // time base
    // ***************************************************************
    // one shared prescaler keeps every sink on the same tick grid
    logic [31:0] pre_cnt;
    logic        tick;
    wire         pre_wrap = (pre_cnt == 32'(BASE_TICK - 1));

    always_ff @(posedge mclk) begin
        if (!reset_n) begin
            pre_cnt <= 32'h0000_0000;
            tick    <= 1'b0;
        end else if (ce) begin
            pre_cnt <= pre_wrap ? 32'h0000_0000 : pre_cnt + 32'h0000_0001;
            tick    <= pre_wrap;
        end
    end

    // ***************************************************************
    // sink engines
    // ***************************************************************
    wire [CODE_W-1:0] lvl [3];

    for (genvar i = 0; i < 3; i++) begin : g_sink
        aibf_sink u_sink (
            .mclk        (mclk),
            .reset_n     (reset_n),
            .ce          (ce),
            .tick        (tick),
            .enable      (sink_enable[i]),
            .law         (fade_law_select),
            .off_disable (off_code[i] == OFF_TIMER_DISABLED),
            .on_tenths   (on_tenths),
            .off_tenths  (OFF_TENTHS[off_code[i]]),
            .fi_tenths   (fi_tenths),
            .fo_tenths   (fo_tenths),
            .code        (code_sel[i]),
            .level       (lvl[i]),
            .lit         (sink_lit[i])
        );
    end

    assign sink0_level = lvl[0];
    assign sink1_level = lvl[1];
    assign sink2_level = lvl[2];

endmodule : aibf_ctrl

// ==== aibf_monitor.sv ====
`timescale 1ns/1ps

// ***************************************************************
// port checker for the blink and fade control block
// ***************************************************************
module aibf_monitor
    import aibf_pkg::*;
#(
    parameter int BASE_TICK = 4         // cycles per base tick
)
(
    input wire logic       mclk,        // clock
    input wire logic       reset_n,     // synchronous reset
    input wire logic       ce,          // clock enable
    input wire logic [7:0] reg_addr,    // register address
    input wire logic [7:0] reg_wdata,   // write byte
    input wire logic       reg_we,      // write strobe
    input wire logic       reg_re,      // read strobe
    input wire logic [7:0] reg_rdata,   // read byte
    input wire logic [2:0] sink_enable, // enable bits
    input wire logic [5:0] sink0_level, // sink 0 code
    input wire logic [5:0] sink1_level, // sink 1 code
    input wire logic [2:0] sink_lit     // conducting flags
);
    default clocking cb @(posedge mclk); endclocking
    default disable iff (!reset_n);

    // shadows of host writes serve as expected values
    logic [7:0] sh_time;
    logic [3:0] sh_fade_in;
    logic [5:0] sh_c0;
    logic [5:0] sh_c1;
    always_ff @(posedge mclk) begin
        if (!reset_n) begin
            sh_time    <= 8'h00;
            sh_fade_in <= 4'h0;
            sh_c0      <= 6'h00;
            sh_c1      <= 6'h00;
        end else if (ce && reg_we) begin
            if (reg_addr == ADDR_BLINK_TIMING) sh_time <= reg_wdata;
            if (reg_addr == ADDR_FADE_TIMING) sh_fade_in <= reg_wdata[3:0];
            if (reg_addr == ADDR_SINK0_CURRENT) sh_c0 <= reg_wdata[5:0];
            if (reg_addr == ADDR_SINK1_CURRENT) sh_c1 <= reg_wdata[5:0];
        end
    end

    // address classes
    wire addr_mapped = (reg_addr >= 8'h12) && (reg_addr <= 8'h16);
    wire addr_code   = (reg_addr >= 8'h14) && (reg_addr <= 8'h16);
    wire rd_only     = ce && reg_re && !reg_we;

    a_reset_clears: assert property ($rose(reset_n) |-> reg_rdata == 8'h00 && sink_lit == 3'h0)
        else $error("outputs not cleared by reset");
    a_unmapped_read: assert property (ce && reg_re && !addr_mapped |=> reg_rdata == 8'h00)
        else $error("unmapped read not zero");
    a_code_top_zero: assert property (ce && reg_re && addr_code |=> reg_rdata[7:6] == 2'h0)
        else $error("unused code bits read nonzero");
    a_code_readback: assert property (rd_only && reg_addr == ADDR_SINK0_CURRENT |=> reg_rdata == {2'h0, sh_c0})
        else $error("sink 0 code readback wrong");
    a_timing_readback: assert property (rd_only && reg_addr == ADDR_BLINK_TIMING |=> reg_rdata == sh_time)
        else $error("timing readback wrong");
    a_rdata_holds: assert property (!(ce && reg_re) |=> $stable(reg_rdata))
        else $error("read byte changed without a read");
    a_disabled_dark: assert property (!sink_enable[0] && sink0_level == 6'h00 |=> sink0_level == 6'h00)
        else $error("disabled sink lit");
    a_enable_wakes: assert property (ce && $rose(sink_enable[1]) && sh_fade_in == 4'h0 && sh_c1 != 6'h00
        && sink1_level == 6'h00 |-> ##[1:3] sink1_level == sh_c1) else $error("sink 1 did not turn on");
    a_steady_hold: assert property (ce && !reg_we && sink_enable[0] && sh_time[1:0] == 2'h0 && sh_c0 != 6'h00
        && sink0_level == sh_c0 |=> sink0_level == sh_c0) else $error("steady sink 0 changed");
endmodule : aibf_monitor

bind aibf_ctrl aibf_monitor #(.BASE_TICK(BASE_TICK)) u_monitor (.mclk, .reset_n, .ce, .reg_addr, .reg_wdata,
    .reg_we, .reg_re, .reg_rdata, .sink_enable, .sink0_level, .sink1_level, .sink_lit);

// ==== aibf_host_model.sv ====
`timescale 1ns/1ps

// ***************************************************************
// host side of the register port
// ***************************************************************
module aibf_host_model
    import aibf_pkg::*;
(
    input  wire logic       mclk,      // clock
    output logic [7:0]      reg_addr,  // register address
    output logic [7:0]      reg_wdata, // write byte
    output logic            reg_we,    // write strobe
    output logic            reg_re,    // read strobe
    input  wire logic [7:0] reg_rdata  // read byte
);
    initial begin
        reg_addr  = 8'h00;
        reg_wdata = 8'h00;
        reg_we    = 1'b0;
        reg_re    = 1'b0;
    end

    // released lines show the inverse so stale values never look valid
    task automatic write_reg(input logic [7:0] a, input logic [7:0] d);
        @(negedge mclk);
        reg_addr  = a;
        reg_wdata = d;
        reg_we    = 1'b1;
        @(negedge mclk);
        reg_we    = 1'b0;
        reg_addr  = ~a;
        reg_wdata = ~d;
    endtask : write_reg

    // read byte lands one edge after the strobe
    task automatic read_reg(input logic [7:0] a, output logic [7:0] d);
        @(negedge mclk);
        reg_addr = a;
        reg_re   = 1'b1;
        @(negedge mclk);
        d        = reg_rdata;
        reg_re   = 1'b0;
        reg_addr = ~a;
    endtask : read_reg
endmodule : aibf_host_model

// ==== aux_indicator_blink_fade_ctrl_bench.sv ====
`timescale 1ns/1ps

// ***************************************************************
// bench: short base tick so 0.1 s is 256 cycles
// ***************************************************************
module aux_indicator_blink_fade_ctrl_bench;
    import aibf_pkg::*;
    localparam int UNIT = 256;
    logic       mclk = 0, reset_n = 0, ce = 1, fade_law_select = 0;
    logic [2:0] sink_enable = 3'h0, sink_lit;
    logic [7:0] reg_addr, reg_wdata, reg_rdata, d;
    logic       reg_we, reg_re;
    logic [5:0] lvl [3];
    int         n_fail = 0, num_checks = 0, n;
    always #10 mclk = ~mclk;

    aibf_ctrl #(.BASE_TICK(4)) dut (.mclk, .reset_n, .ce, .reg_addr, .reg_wdata, .reg_we, .reg_re, .reg_rdata,
        .sink_enable, .fade_law_select, .sink0_level(lvl[0]), .sink1_level(lvl[1]), .sink2_level(lvl[2]), .sink_lit);
    aibf_host_model host (.mclk, .reg_addr, .reg_wdata, .reg_we, .reg_re, .reg_rdata);

    task automatic check(input string name, input logic [15:0] seen, input logic [15:0] exp);
        num_checks++;
        if (seen !== exp) begin
            n_fail++;
            $display("ERROR %s expected %h seen %h", name, exp, seen);
        end
    endtask : check

    task automatic give_verdict;
        if (n_fail == 0 && num_checks > 0) $display("verification passed");
        else $display("verification failed");
        $finish;
    endtask : give_verdict

    // bounded wait for a sink flag, counting cycles
    task automatic wait_lit(input int s, input logic v, output int k);
        k = 0;
        while (sink_lit[s] !== v) begin
            @(negedge mclk);
            k++;
            if (k > 5000) begin
                n_fail++;
                give_verdict();
            end
        end
    endtask : wait_lit

    // reset values, masks, unmapped place, frozen clock enable
    task automatic t_registers;
        logic [7:0] mask [5] = '{8'hff, 8'hff, 8'h3f, 8'h3f, 8'h3f};
        for (int i = 0; i < 5; i++) begin
            host.read_reg(8'(8'h12 + i), d);
            check("reset value", d, 16'h0);
            host.write_reg(8'(8'h12 + i), 8'hff);
            host.read_reg(8'(8'h12 + i), d);
            check("readback", d, mask[i]);
        end
        host.write_reg(8'h17, 8'hff);
        host.read_reg(8'h17, d);
        check("unmapped", d, 16'h0);
        ce = 1'b0;
        host.write_reg(8'h12, 8'h00);
        ce = 1'b1;
        host.read_reg(8'h12, d);
        check("frozen write", d, 16'hff);
        for (int i = 0; i < 5; i++) host.write_reg(8'(8'h12 + i), 8'h00);
    endtask : t_registers

    // own codes, own enables, steady light with timer off
    task automatic t_independent;
        logic [5:0] c [3] = '{6'h15, 6'h2a, 6'h3f};
        for (int i = 0; i < 3; i++) host.write_reg(8'(8'h14 + i), {2'h0, c[i]});
        sink_enable = 3'h7;
        repeat (6) @(negedge mclk);
        for (int i = 0; i < 3; i++) check("own code", lvl[i], c[i]);
        sink_enable = 3'h5;
        repeat (6) @(negedge mclk);
        check("sink 1 off", lvl[1], 16'h0);
        check("sink 2 kept", lvl[2], c[2]);
        repeat (3000) @(negedge mclk);
        check("steady", lvl[0], c[0]);
        sink_enable = 3'h0;
        repeat (6) @(negedge mclk);
    endtask : t_independent

    // every on code against the off fields of rotating sinks
    task automatic t_blink;
        int on_t [4] = '{2, 6, 8, 12};
        int off_t [4] = '{0, 6, 8, 12};
        int s, j;
        for (int i = 0; i < 4; i++) begin
            s = i % 3;
            j = (i == 0) ? 1 : i;
            host.write_reg(ADDR_BLINK_TIMING, 8'((i << 6) | (j << (2 * s))));
            sink_enable = 3'(1 << s);
            wait_lit(s, 1'b1, n);
            wait_lit(s, 1'b0, n);
            wait_lit(s, 1'b1, n);
            check("off time", 16'(n >= off_t[j] * UNIT - 8 && n <= off_t[j] * UNIT + 8), 16'h1);
            wait_lit(s, 1'b0, n);
            check("on time", 16'(n >= on_t[i] * UNIT - 8 && n <= on_t[i] * UNIT + 8), 16'h1);
            sink_enable = 3'h0;
            host.write_reg(ADDR_BLINK_TIMING, 8'h00);
        end
    endtask : t_blink

    // 0.3 s fades: midpoint shows the law, ends show full and dark
    task automatic t_fade(input logic law);
        int mid;
        mid = law ? 15 : 31;
        host.write_reg(ADDR_SINK0_CURRENT, 8'h3f);
        host.write_reg(ADDR_FADE_TIMING, 8'h11);
        fade_law_select = law;
        sink_enable = 3'h1;
        repeat (384) @(negedge mclk);
        check("fade in mid", 16'(lvl[0] >= mid - 4 && lvl[0] <= mid + 4), 16'h1);
        repeat (450) @(negedge mclk);
        check("fade in end", lvl[0], 16'h3f);
        sink_enable = 3'h0;
        repeat (384) @(negedge mclk);
        check("fade out mid", 16'(lvl[0] >= mid - 4 && lvl[0] <= mid + 4), 16'h1);
        repeat (450) @(negedge mclk);
        check("fade out end", lvl[0], 16'h0);
        host.write_reg(ADDR_FADE_TIMING, 8'h00);
    endtask : t_fade

    // 3.5 s fade-in on the half-second branch of the table, fade-out left disabled
    task automatic t_long_fade;
        fade_law_select = 1'b0;
        host.write_reg(ADDR_SINK0_CURRENT, 8'h3f);
        host.write_reg(ADDR_FADE_TIMING, 8'h0b);
        sink_enable = 3'h1;
        repeat (4480) @(negedge mclk);
        check("long fade mid", 16'(lvl[0] >= 27 && lvl[0] <= 35), 16'h1);
        repeat (4600) @(negedge mclk);
        check("long fade end", lvl[0], 16'h3f);
        sink_enable = 3'h0;
        repeat (6) @(negedge mclk);
        check("no fade out", lvl[0], 16'h0);
        host.write_reg(ADDR_FADE_TIMING, 8'h00);
    endtask : t_long_fade

    // main sequence
    initial begin
        repeat (20) @(negedge mclk);
        reset_n = 1'b1;
        t_registers();
        t_independent();
        t_blink();
        t_fade(1'b0);
        t_fade(1'b1);
        t_long_fade();
        give_verdict();
    end
endmodule : aux_indicator_blink_fade_ctrl_bench
